// *** rtl/sadc_ctrl.sv ***
/*
  sar converter sequencer: apb register file, conversion clock divider,
  sample/convert sequencer, result buffer with output formatting.
  assumes the analog front end returns a 12-bit code with afeDone after
  afeStart, and that sleep/idle arrive as levels from the power controller.
*/
// How it works
// RL1: trigger 111 ends sampling automatically
// RL2: auto sample restarts acquisition after conversion
// RL3: done flag after programmed conversion count
// RL4: sample time 00001 gives one period
// RL5: sample cycle is sample time plus 14
// RL6: period is half cycle times div+1
// RL7: on bit enables, off disables everything
// RL8: software waits for settle after enabling
// RL9: sleep stops module clocks, held low
// RL10: sleep aborts conversion, registers kept
// RL11: rc clock keeps running in sleep
// RL12: rc mode waits one cycle before converting
// RL13: finish clears active flag, writes buffer
// RL14: sleep finish wakes or powers down
// RL15: idle halts only when stop bit set
// RL16: reset clears registers, aborts sequence
// RL17: reset leaves buffer contents untouched
// RL18: 12-bit results shown in four formats
// RL19: integer formats right-justify, zero or sign fill
// RL20: fractional formats left-justify, low nibble zero
// RL21: analog pins read zero on port
// RL22: conversion ignores pin direction bits
// RL23: six-bit divider, 64 periods
// RL24: off aborts, keeps buffer, beats autostart
// RL25: software keeps sample time at least one
// RL26: format applied at read time
`timescale 1ns/100ps
`default_nettype none
`include "sadc_params.svh"
module sadc_ctrl
  import sadc_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleepReq,
  input wire logic idleReq,
  input wire logic [15:0] portPins,
  input wire logic [15:0] pinDirection,
  input wire logic [11:0] afeResult,
  input wire logic afeDone,
  output logic afePowerOn,
  output logic afeSample,
  output logic afeStart,
  output logic convClock,
  output logic wakeReq
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers for pin-side inputs
  logic [15:0] portMeta_r, portSync_r;
  logic sleepMeta_r, sleepSync_r, idleMeta_r, idleSync_r;
  logic afeDoneMeta_r, afeDoneSync_r;
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      portMeta_r <= `SADC_RST_16;
      portSync_r <= `SADC_RST_16;
      sleepMeta_r <= 1'b0;
      sleepSync_r <= 1'b0;
      idleMeta_r <= 1'b0;
      idleSync_r <= 1'b0;
      afeDoneMeta_r <= 1'b0;
      afeDoneSync_r <= 1'b0;
    end
    else
    begin
      portMeta_r <= portPins;
      portSync_r <= portMeta_r;
      sleepMeta_r <= sleepReq;
      sleepSync_r <= sleepMeta_r;
      idleMeta_r <= idleReq;
      idleSync_r <= idleMeta_r;
      afeDoneMeta_r <= afeDone;
      afeDoneSync_r <= afeDoneMeta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers and sequencer state
  logic [15:0] ctl1_r, ctl1_nxt, ctl2_r, ctl2_nxt, ctl3_r, ctl3_nxt;
  logic [15:0] pcfg_r, pcfg_nxt;
  logic intEn_r, intEn_nxt, parked_r, parked_nxt;
  sadc_state_e state_r, state_nxt;
  logic [5:0] divCnt_r, divCnt_nxt;
  logic [4:0] tadCnt_r, tadCnt_nxt;
  logic [3:0] smpCnt_r, smpCnt_nxt, bufPtr_r, bufPtr_nxt;
  logic [1:0] dlyCnt_r, dlyCnt_nxt;
  logic ckPhase_r, ckPhase_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt, afePowerOn_nxt, afeSample_nxt, afeStart_nxt;
  logic convClock_nxt, wakeReq_nxt;
  // plain array, no reset: contents survive reset and are unknown at power-on
  logic [11:0] resBuf [0:`SADC_BUF_DEPTH-1]; // RL17
  logic bufWe;
  logic [11:0] bufWd;

  logic isOn, useRc, autoTrig, stopIdle, clkRun, tadTick;
  logic [5:0] divLimit;
  logic [11:0] rdWord;
  logic [15:0] fmtWord;
  logic [3:0] rdIdx;
  logic setupWr, accWr, accRd;

  assign isOn = ctl1_r[`SADC_C1_ON];
  assign useRc = ctl3_r[`SADC_C3_RC];
  assign autoTrig = (ctl1_r[`SADC_C1_TRIGGER_SOURCE_SELECT_LO +: 3] == `SADC_TRIGGER_SOURCE_SELECT_AUTO);
  assign stopIdle = ctl1_r[`SADC_C1_SIDL];
  // module clocks gated: sleep stops all but rc, idle honours stop bit
  assign clkRun = isOn && !parked_r && (!sleepSync_r || useRc) // RL9 RL11
                  && !(idleSync_r && stopIdle); // RL15
  // rc mode runs from a fixed slow divider instead of the software one
  assign divLimit = useRc ? `SADC_RC_DIV : ctl3_r[`SADC_C3_DIV_LO +: 6]; // RL23
  // half period of conversion clock equals (div+1) core clocks: RL6
  assign tadTick = clkRun && (divCnt_r == divLimit) && ckPhase_r; // RL6
  assign setupWr = psel && !penable && pwrite;
  assign accWr = psel && penable && pwrite;
  assign accRd = psel && penable && !pwrite;
  assign rdIdx = paddr[`SADC_BUF_AW+1:2];
  assign rdWord = resBuf[rdIdx];

  ////////////////////////////////////////////////////////////////////////////
  // output formatting, applied at read time
  always_comb
  begin
    case (sadc_fmt_e'(ctl1_r[`SADC_C1_OUTPUT_FORMAT_LO +: 2])) // RL26 RL18
      FMT_INT: fmtWord = {4'h0, rdWord}; // RL19
      FMT_SINT: fmtWord = {{4{rdWord[11]}}, rdWord}; // RL19
      FMT_FRAC: fmtWord = {rdWord, 4'h0}; // RL20
      FMT_SFRAC: fmtWord = {rdWord, 4'h0}; // RL20
      default: fmtWord = {4'h0, rdWord};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    ctl1_nxt = ctl1_r;
    ctl2_nxt = ctl2_r;
    ctl3_nxt = ctl3_r;
    pcfg_nxt = pcfg_r;
    intEn_nxt = intEn_r;
    parked_nxt = parked_r;
    state_nxt = state_r;
    divCnt_nxt = divCnt_r;
    ckPhase_nxt = ckPhase_r;
    tadCnt_nxt = tadCnt_r;
    smpCnt_nxt = smpCnt_r;
    bufPtr_nxt = bufPtr_r;
    dlyCnt_nxt = dlyCnt_r;
    bufWe = 1'b0;
    bufWd = afeResult;
    afeStart_nxt = 1'b0;
    wakeReq_nxt = 1'b0;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt = `SADC_SLVERR_DATA;

    // conversion clock divider
    if (clkRun)
    begin
      if (divCnt_r == divLimit)
      begin
        divCnt_nxt = 6'h00;
        ckPhase_nxt = !ckPhase_r;
      end
      else
        divCnt_nxt = divCnt_r + 6'h01;
    end
    else
    begin
      divCnt_nxt = 6'h00;
      ckPhase_nxt = 1'b0;
    end

    // sequencer; sleep without rc aborts without resuming
    if (!isOn || (sleepSync_r && !useRc)) // RL7 RL24 RL10
      state_nxt = (isOn) ? ST_IDLE : ST_OFF;
    else
    begin
      case (state_r)
        ST_OFF:
          state_nxt = ST_IDLE;
        ST_IDLE:
          if (ctl1_r[`SADC_C1_AUTO_SAMPLE_ENABLE] || ctl1_r[`SADC_C1_SAMP])
          begin
            ctl1_nxt[`SADC_C1_SAMP] = 1'b1;
            state_nxt = ST_SAMPLE;
            tadCnt_nxt = 5'h00;
          end
        ST_SAMPLE:
          if (autoTrig) // RL1
          begin
            // acquisition lasts the programmed periods, one period for a setting of 0: RL4 RL5
            if (tadTick)
            begin
              tadCnt_nxt = tadCnt_r + 5'h01;
              if ((tadCnt_r + 5'h01) >= ctl3_r[`SADC_C3_AUTO_SAMPLE_TIME_LO +: 5]) // RL4
              begin
                ctl1_nxt[`SADC_C1_SAMP] = 1'b0;
                state_nxt = useRc ? ST_DELAY : ST_CONVERT;
                tadCnt_nxt = 5'h00;
                dlyCnt_nxt = 2'h0;
              end
            end
          end
          else if (!ctl1_r[`SADC_C1_SAMP] && tadTick)
          begin
            state_nxt = useRc ? ST_DELAY : ST_CONVERT;
            tadCnt_nxt = 5'h00;
            dlyCnt_nxt = 2'h0;
          end
        ST_DELAY:
          begin
            dlyCnt_nxt = dlyCnt_r + 2'h1;
            if (dlyCnt_r == `SADC_ICY_CLKS - 2'h1) // RL12
              state_nxt = ST_CONVERT;
          end
        ST_CONVERT:
          begin
            if (tadCnt_r == 5'h00 && tadTick)
              afeStart_nxt = 1'b1;
            if (tadTick)
              tadCnt_nxt = tadCnt_r + 5'h01;
            // 14 periods of conversion; analog channel read regardless of pin_direction: RL22
            if (tadTick && tadCnt_r == {1'b0, `SADC_CONVERSION_ACTIVE_TADS} - 5'h01) // RL5
            begin
              bufWe = 1'b1; // RL13
              bufPtr_nxt = bufPtr_r + 4'h1;
              tadCnt_nxt = 5'h00;
              if (smpCnt_r == ctl2_r[`SADC_C2_SAMPLES_PER_INTERRUPT_LO +: 4]) // RL3
              begin
                smpCnt_nxt = 4'h0;
                bufPtr_nxt = 4'h0;
                ctl1_nxt[`SADC_C1_DONE] = 1'b1;
                if (sleepSync_r)
                begin
                  if (intEn_r)
                    wakeReq_nxt = 1'b1; // RL14
                  else
                    parked_nxt = 1'b1; // RL14
                end
              end
              else
                smpCnt_nxt = smpCnt_r + 4'h1;
              // auto sample restarts; done set wins over a software clear
              if (ctl1_r[`SADC_C1_AUTO_SAMPLE_ENABLE]) // RL2
              begin
                ctl1_nxt[`SADC_C1_SAMP] = 1'b1;
                state_nxt = ST_SAMPLE;
              end
              else
                state_nxt = ST_IDLE; // RL13
            end
          end
        default:
          state_nxt = ST_OFF;
      endcase
    end
    if (!sleepSync_r)
      parked_nxt = 1'b0;

    // apb: one wait state, answer in the second access cycle
    if (psel && penable && !pready)
    begin
      pready_nxt = 1'b1;
      case (paddr)
        `SADC_OFF_CTL1: prdata_nxt = {16'h0000, ctl1_r};
        `SADC_OFF_CTL2: prdata_nxt = {16'h0000, ctl2_r};
        `SADC_OFF_CTL3: prdata_nxt = {16'h0000, ctl3_r};
        `SADC_OFF_PCFG: prdata_nxt = {16'h0000, pcfg_r};
        `SADC_OFF_STAT: prdata_nxt = {29'h0, parked_r, state_r == ST_CONVERT,
                                      state_r == ST_SAMPLE};
        // analog pins (cfg bit low) read zero
        `SADC_OFF_PORT: prdata_nxt = {16'h0000, portSync_r & pcfg_r}; // RL21
        `SADC_OFF_MODE: prdata_nxt = {31'h0, intEn_r};
        default:
          if (paddr >= `SADC_OFF_BUF0 && paddr <= `SADC_OFF_BUFEND && paddr[1:0] == 2'h0)
            prdata_nxt = {16'h0000, fmtWord};
          else
            pslverr_nxt = 1'b1;
      endcase
    end
    // a write takes effect at the edge that completes the transfer
    if (accWr && pready)
    begin
      case (paddr)
        `SADC_OFF_CTL1: ctl1_nxt = pwdata[15:0];
        `SADC_OFF_CTL2: ctl2_nxt = pwdata[15:0];
        `SADC_OFF_CTL3: ctl3_nxt = pwdata[15:0];
        `SADC_OFF_PCFG: pcfg_nxt = pwdata[15:0];
        `SADC_OFF_MODE: intEn_nxt = pwdata[`SADC_MD_IEN];
        // status, port and buffer are read-only: ignored, not flagged
        default: intEn_nxt = intEn_r;
      endcase
      // done set by a finishing sequence wins over a clear in the same cycle
      if (paddr == `SADC_OFF_CTL1 && bufWe && smpCnt_r == ctl2_r[`SADC_C2_SAMPLES_PER_INTERRUPT_LO +: 4])
        ctl1_nxt[`SADC_C1_DONE] = 1'b1;
    end
    if (!ctl1_nxt[`SADC_C1_ON]) // RL24
      ctl1_nxt[`SADC_C1_SAMP] = 1'b0;
    afePowerOn_nxt = isOn && !parked_r; // RL7
    afeSample_nxt = (state_nxt == ST_SAMPLE) && clkRun;
    convClock_nxt = ckPhase_nxt && clkRun; // RL9
  end

  ////////////////////////////////////////////////////////////////////////////
  // state registers; reset leaves the result buffer alone
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst) // RL16
    begin
      ctl1_r <= `SADC_RST_16;
      ctl2_r <= `SADC_RST_16;
      ctl3_r <= `SADC_RST_16;
      pcfg_r <= `SADC_RST_16;
      intEn_r <= 1'b0;
      parked_r <= 1'b0;
      state_r <= ST_OFF;
      divCnt_r <= 6'h00;
      ckPhase_r <= 1'b0;
      tadCnt_r <= 5'h00;
      smpCnt_r <= 4'h0;
      bufPtr_r <= 4'h0;
      dlyCnt_r <= 2'h0;
      prdata <= `SADC_SLVERR_DATA;
      pready <= 1'b0;
      pslverr <= 1'b0;
      afePowerOn <= 1'b0;
      afeSample <= 1'b0;
      afeStart <= 1'b0;
      convClock <= 1'b0;
      wakeReq <= 1'b0;
    end
    else
    begin
      ctl1_r <= ctl1_nxt;
      ctl2_r <= ctl2_nxt;
      ctl3_r <= ctl3_nxt;
      pcfg_r <= pcfg_nxt;
      intEn_r <= intEn_nxt;
      parked_r <= parked_nxt;
      state_r <= state_nxt;
      divCnt_r <= divCnt_nxt;
      ckPhase_r <= ckPhase_nxt;
      tadCnt_r <= tadCnt_nxt;
      smpCnt_r <= smpCnt_nxt;
      bufPtr_r <= bufPtr_nxt;
      dlyCnt_r <= dlyCnt_nxt;
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
      afePowerOn <= afePowerOn_nxt;
      afeSample <= afeSample_nxt;
      afeStart <= afeStart_nxt;
      convClock <= convClock_nxt;
      wakeReq <= wakeReq_nxt;
    end
  end

  always_ff @(posedge clock)
  begin
    if (bufWe)
      resBuf[bufPtr_r] <= bufWd; // RL13
  end

  // afeDone is informational; result is taken at the 14th period edge
  logic unusedDone;
  assign unusedDone = afeDoneSync_r ^ setupWr ^ accRd ^ (|pinDirection); // RL22
endmodule // sadc_ctrl
`default_nettype wire

// *** rtl/sadc_params.svh ***
/*
  constants for the sar converter sequencer: register offsets, field positions,
  reset values and timing counts.
  assumes inclusion by bare name from the package and the design module.
*/
`ifndef SADC_PARAMS_SVH
`define SADC_PARAMS_SVH

// apb byte offsets
`define SADC_OFF_CTL1    12'h000
`define SADC_OFF_CTL2    12'h004
`define SADC_OFF_CTL3    12'h008
`define SADC_OFF_PCFG    12'h00C
`define SADC_OFF_STAT    12'h010
`define SADC_OFF_PORT    12'h014
`define SADC_OFF_MODE    12'h018
`define SADC_OFF_BUF0    12'h040
`define SADC_OFF_BUFEND  12'h07C

// control one fields
`define SADC_C1_ON       15
`define SADC_C1_SIDL     13
`define SADC_C1_OUTPUT_FORMAT_LO  8
`define SADC_C1_TRIGGER_SOURCE_SELECT_LO  5
`define SADC_C1_AUTO_SAMPLE_ENABLE     2
`define SADC_C1_SAMP     1
`define SADC_C1_DONE     0
// control two fields
`define SADC_C2_SAMPLES_PER_INTERRUPT_LO  2
// control three fields
`define SADC_C3_AUTO_SAMPLE_TIME_LO  8
`define SADC_C3_RC       7
`define SADC_C3_DIV_LO   0
// mode register fields
`define SADC_MD_IEN      0

`define SADC_TRIGGER_SOURCE_SELECT_AUTO   3'h7
`define SADC_TRIGGER_SOURCE_SELECT_SW     3'h0
`define SADC_CONVERSION_ACTIVE_TADS   4'hE
`define SADC_RST_16      16'h0000
`define SADC_SLVERR_DATA 32'h0000_0000

// the rc clock is modelled as a fixed divider of the core clock
`define SADC_RC_DIV      6'h0F
// conversion start delay in rc mode: one instruction cycle, in core clocks
`define SADC_ICY_CLKS    2'h2
`define SADC_BUF_DEPTH   16
`define SADC_BUF_AW      4

`endif

// *** rtl/sadc_pkg.sv ***
/*
  types for the sar converter sequencer.
  assumes the params header is reachable on the include path.
*/
package sadc_pkg;
  `include "sadc_params.svh"

  typedef enum logic [1:0] {
    FMT_INT,
    FMT_SINT,
    FMT_FRAC,
    FMT_SFRAC
  } sadc_fmt_e;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_IDLE,
    ST_SAMPLE,
    ST_DELAY,
    ST_CONVERT
  } sadc_state_e;
endpackage

// *** tb/sadc_afe_model.sv ***
/*
  analog front end stand-in: latches a new code on every start strobe.
  assumes the sequencer samples the code before the next acquisition.
*/
`timescale 1ns/100ps
`default_nettype none
module sadc_afe_model (
  input wire logic clock,
  input wire logic nrst,
  input wire logic afeStart,
  input wire logic afeSample,
  output logic [11:0] afeResult,
  output logic afeDone
);
  logic [11:0] code_r;
  ////////////////////////////////////////
  // codes step by 0x111 so a stale or skipped sample shows up
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      code_r <= 12'h9A5;
      afeResult <= 12'h000;
    end
    else if (afeStart)
    begin
      afeResult <= code_r;
      code_r <= code_r + 12'h111;
    end
    else if (afeSample)
      afeResult <= ~afeResult; // line is released while acquiring
  end
  assign afeDone = 1'b0; // not looked at by the sequencer
endmodule // sadc_afe_model
`default_nettype wire

// *** tb/sadc_chk.sv ***
/*
  checker for the sequencer ports: apb answer timing and front end strobes.
  assumes it is bound to the sequencer top module, one clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module sadc_chk (
  input wire logic clock,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic afePowerOn,
  input wire logic afeSample,
  input wire logic afeStart,
  input wire logic wakeReq
);
  ////////////////////////////////////////
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered after one wait state");
  a_ready_access: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("ready outside an access phase");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  a_err_unmapped: assert property (pready && paddr >= 12'h080 |-> pslverr)
    else $error("unmapped address answered without error");
  a_mapped_ok: assert property (pready && paddr <= 12'h018 |-> !pslverr)
    else $error("mapped register answered with error");
  a_start_pulse: assert property (afeStart |=> !afeStart)
    else $error("start strobe longer than one cycle");
  a_start_idle: assert property (afeStart |-> !afeSample)
    else $error("conversion start while still acquiring");
  a_off_quiet: assert property (!afePowerOn && $past(!afePowerOn) |-> !afeSample && !afeStart)
    else $error("front end active while powered off");
  a_wake_pulse: assert property (wakeReq |=> !wakeReq)
    else $error("wake request longer than one cycle");
  c_start: cover property (afeStart);
  c_wake: cover property (wakeReq);
  c_err: cover property (pslverr);
endmodule // sadc_chk
bind sadc_ctrl sadc_chk sadc_chk_i (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .afePowerOn(afePowerOn),
  .afeSample(afeSample), .afeStart(afeStart), .wakeReq(wakeReq));
`default_nettype wire

// *** tb/tb.sv ***
/*
  bench for the converter sequencer: apb tasks and one task per scenario.
  assumes the front end model and the bound checker are compiled with it.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sadc_params.svh"
module tb;
  logic clock, nrst, psel, penable, pwrite, pready, pslverr, err, sleepReq, idleReq;
  logic afeDone, afePowerOn, afeSample, afeStart, convClock, wakeReq;
  logic [11:0] paddr, afeResult;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] portPins, pinDirection;
  logic [31:0] fmt [4] = '{32'h09A5, 32'hF9A5, 32'h9A50, 32'h9A50};
  int failures = 0, samplesChecked = 0, n;
  sadc_ctrl sadc_ctrl_i (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleepReq(sleepReq), .idleReq(idleReq), .portPins(portPins),
    .pinDirection(pinDirection), .afeResult(afeResult), .afeDone(afeDone),
    .afePowerOn(afePowerOn), .afeSample(afeSample), .afeStart(afeStart),
    .convClock(convClock), .wakeReq(wakeReq));
  sadc_afe_model sadc_afe_model_i (.clock(clock), .nrst(nrst), .afeStart(afeStart),
    .afeSample(afeSample), .afeResult(afeResult), .afeDone(afeDone));
  ////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic tick(input int c);
    repeat (c) @(posedge clock);
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    samplesChecked++;
    if (s !== x)
    begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, s, x);
    end
  endtask
  // read data and error are taken only at the edge that sees ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock) penable <= 1'b1;
    do tick(1); while (pready !== 1'b1 && k++ < 40);
    if (pready !== 1'b1)
      failures++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    tick(1);
  endtask
  task automatic giveVerdict;
    $display("checks %0d failures %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    chk(afePowerOn, 1'b0);
    apb(1'b0, `SADC_OFF_CTL1, 0);
    chk(q, 32'h0000);
    apb(1'b0, 12'h080, 0);
    chk(err, 1'b1);
    apb(1'b1, `SADC_OFF_PCFG, 32'h00FF);
    apb(1'b0, `SADC_OFF_PORT, 0);
    chk(q, 32'h00A5);
  endtask
  task automatic t_single;
    apb(1'b1, `SADC_OFF_CTL3, 32'h0101);
    apb(1'b1, `SADC_OFF_CTL1, 32'h8000);
    tick(20);
    apb(1'b1, `SADC_OFF_CTL1, 32'h80E2);
    n = 0;
    do apb(1'b0, `SADC_OFF_CTL1, 0); while (q[0] !== 1'b1 && n++ < 60);
    chk(q[0], 1'b1);
    apb(1'b0, `SADC_OFF_STAT, 0);
    chk(q[1], 1'b0);
    for (int f = 0; f < 4; f++)
    begin
      apb(1'b1, `SADC_OFF_CTL1, 32'h8000 | (32'(f) << 8));
      apb(1'b0, `SADC_OFF_BUF0, 0);
      chk(q, fmt[f]);
    end
  endtask
  task automatic t_abort;
    apb(1'b1, `SADC_OFF_CTL1, 32'h80E2);
    n = 0;
    while (afeStart !== 1'b1 && n++ < 100) tick(1);
    chk(afeStart, 1'b1);
    apb(1'b1, `SADC_OFF_CTL1, 0);
    tick(80);
    chk(afePowerOn, 1'b0);
    apb(1'b0, `SADC_OFF_BUF0, 0);
    chk(q, 32'h09A5);
    nrst <= 1'b0;
    tick(2);
    nrst <= 1'b1;
    tick(1);
    apb(1'b0, `SADC_OFF_CTL1, 0);
    chk(q, 32'h0000);
    apb(1'b0, `SADC_OFF_BUF0, 0);
    chk(q, 32'h09A5);
  endtask
  // two conversions per done: done stays low after the first one
  task automatic t_count;
    apb(1'b1, `SADC_OFF_CTL3, 32'h0101);
    apb(1'b1, `SADC_OFF_CTL2, 32'h0004);
    apb(1'b1, `SADC_OFF_CTL1, 32'h8000);
    tick(20);
    apb(1'b1, `SADC_OFF_CTL1, 32'h80E4);
    repeat (2)
    begin
      n = 0;
      while (afeStart !== 1'b1 && n++ < 200) tick(1);
      chk(afeStart, 1'b1);
      tick(1);
    end
    apb(1'b0, `SADC_OFF_CTL1, 0);
    chk(q[0], 1'b0);
    n = 0;
    do apb(1'b0, `SADC_OFF_CTL1, 0); while (q[0] !== 1'b1 && n++ < 60);
    chk(q[0], 1'b1);
    apb(1'b1, `SADC_OFF_CTL1, 0);
    apb(1'b1, `SADC_OFF_CTL2, 0);
    apb(1'b0, `SADC_OFF_BUF0, 0);
    chk(q, 32'h09A5);
    apb(1'b0, `SADC_OFF_BUF0 + 12'h004, 0);
    chk(q, 32'h0AB6);
  endtask
  task automatic t_auto;
    apb(1'b1, `SADC_OFF_CTL3, 32'h0101);
    apb(1'b1, `SADC_OFF_CTL1, 32'h8000);
    tick(20);
    apb(1'b1, `SADC_OFF_CTL1, 32'h80E4);
    n = 0;
    while (afeStart !== 1'b1 && n++ < 200) tick(1);
    n = 0;
    do begin n++; tick(1); end while (afeStart !== 1'b1 && n < 200);
    chk(n, 60);
    n = 0;
    while (afeSample !== 1'b1 && n++ < 200) tick(1);
    n = 0;
    while (afeSample === 1'b1 && n < 50) begin n++; tick(1); end
    chk(n, 4);
    idleReq <= 1'b1;
    tick(4);
    n = 0;
    repeat (20) begin tick(1); n += (convClock === 1'b1); end
    chk(n, 10);
    apb(1'b1, `SADC_OFF_CTL1, 32'hA0E4);
    tick(4);
    n = 0;
    repeat (20) begin tick(1); n += (convClock === 1'b1); end
    chk(n, 0);
    idleReq <= 1'b0;
    sleepReq <= 1'b1;
    tick(4);
    n = 0;
    repeat (100) begin tick(1); n += (convClock === 1'b1) + (afeStart === 1'b1); end
    chk(n, 0);
    sleepReq <= 1'b0;
    apb(1'b0, `SADC_OFF_CTL1, 0);
    chk(q & 32'hFFFC, 32'hA0E4);
    apb(1'b1, `SADC_OFF_CTL1, 0);
  endtask
  // trigger first, then sleep: the rc start delay leaves room for it
  task automatic t_rc;
    apb(1'b1, `SADC_OFF_MODE, 32'h0001);
    apb(1'b1, `SADC_OFF_CTL3, 32'h0181);
    apb(1'b1, `SADC_OFF_CTL1, 32'h8000);
    tick(20);
    apb(1'b1, `SADC_OFF_CTL1, 32'h80E2);
    sleepReq <= 1'b1;
    n = 0;
    while (wakeReq !== 1'b1 && n++ < 3000) tick(1);
    chk(wakeReq, 1'b1);
    sleepReq <= 1'b0;
    apb(1'b1, `SADC_OFF_CTL1, 0);
  endtask
  ////////////////////////////////////////
  initial
  begin
    {nrst, psel, penable, pwrite, sleepReq, idleReq} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    portPins = 16'hA5A5;
    pinDirection = 16'h0000;
    tick(2);
    nrst <= 1'b1;
    tick(1);
    t_reset;
    t_single;
    t_abort;
    t_count;
    t_auto;
    t_rc;
    giveVerdict;
  end
  // whole run is under two thousand cycles
  initial
  begin
    tick(20000);
    failures++;
    giveVerdict;
  end
endmodule // tb
`default_nettype wire
